/* File: src/gpc_pkg.sv */
// constants for the output, clocking and power-good configuration block
package gpc_pkg;
    localparam logic [7:0] ADDR_OUT_A_DELAY = 8'h10;
    localparam logic [7:0] ADDR_OUT_B_DELAY = 8'h11;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h12;
    localparam logic [7:0] ADDR_MISC = 8'h13;
    localparam logic [7:0] ADDR_LOOP = 8'h14;
    localparam logic [7:0] ADDR_POWER_OK_OUTPUT = 8'h15;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [7:0] RST_OUT_CTRL = 8'h44;
    localparam logic [7:0] OUT_CTRL_WMASK = 8'h77;
    localparam logic [7:0] RST_MISC = 8'h1f;
    localparam logic [7:0] RST_LOOP = 8'h01;
    localparam logic [7:0] RST_POWER_OK_OUTPUT = 8'h70;
    localparam int B_LEVEL_A = 0;
    localparam int B_GATE_A = 1;
    localparam int B_OD_A = 2;
    localparam int B_LEVEL_B = 4;
    localparam int B_GATE_B = 5;
    localparam int B_OD_B = 6;
    localparam int M_SPREAD = 0;
    localparam int M_THERM = 1;
    localparam int M_ENABLE_PIN_PULLDOWN = 2;
    localparam int M_CLK_PD = 3;
    localparam int M_PIN_FN = 4;
    localparam int M_STOP_SEL = 5;
    localparam int M_START_SEL = 6;
    localparam int L_LOOP_EN = 6;
    localparam int P_WIN_SW = 4;
    localparam int P_WIN_LIN = 5;
    localparam int P_OD = 6;
    localparam int P_POL = 7;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned STEP_FINE_US = 500;
    localparam int unsigned STEP_COARSE_US = 1000;
    localparam int unsigned PRESENCE_NS = 2000;
    localparam int unsigned PRESENCE_CYCLES = PRESENCE_NS * CLK_MHZ / 1000;
    localparam int CNT_W = 18;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h60;
endpackage

/* File: src/gpc_delay_if.sv */
// interface between the register logic and one enable delay timer
`timescale 1ns/1ps
`default_nettype none
interface gpc_delay_if;
    logic enable_level;
    logic [3:0] start_code;
    logic [3:0] stop_code;
    logic start_coarse;
    logic stop_coarse;
    logic delayed;
    modport ctrl (output enable_level, start_code, stop_code, start_coarse, stop_coarse,
        input delayed);
    modport timer (input enable_level, start_code, stop_code, start_coarse, stop_coarse,
        output delayed);
endinterface
`default_nettype wire

/* File: src/gpc_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gpc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] filtered
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } gpc_sync_state_type;
    gpc_sync_state_type st, next_st;
    always_comb begin
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // a bit moves only once stages two and three agree
        next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {INIT, INIT, INIT, INIT};
        end else begin
            st <= next_st;
        end
    end
    assign filtered = st.filt;
endmodule
`default_nettype wire

/* File: src/gpc_delay.sv */
// startup and shutdown delay timer for one gated output
`timescale 1ns/1ps
`default_nettype none
module gpc_delay #(
    parameter int unsigned FINE_CYCLES = 125000,
    parameter int unsigned COARSE_CYCLES = 250000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // timer side
    gpc_delay_if.timer dl
);
    typedef struct packed {
        logic out;
        logic en_d;
        logic [gpc_pkg::CNT_W-1:0] tick;
        logic [3:0] step;
    } gpc_delay_state_type;
    gpc_delay_state_type st, next_st;
    logic [3:0] code;
    logic [gpc_pkg::CNT_W-1:0] last;
    assign code = dl.enable_level ? dl.start_code : dl.stop_code;
    assign last = (dl.enable_level ? dl.start_coarse : dl.stop_coarse)
        ? gpc_pkg::CNT_W'(COARSE_CYCLES - 1) : gpc_pkg::CNT_W'(FINE_CYCLES - 1);
    always_comb begin
        next_st = st;
        next_st.en_d = dl.enable_level;
        // an edge of enable restarts the wait from zero
        if (dl.enable_level != st.en_d) begin
            next_st.tick = '0;
            next_st.step = '0;
        end else if (dl.enable_level != st.out) begin
            if (st.step == code) begin
                next_st.out = dl.enable_level;
            end else if (st.tick == last) begin
                next_st.tick = '0;
                next_st.step = st.step + 4'h1;
            end else begin
                next_st.tick = st.tick + gpc_pkg::CNT_W'(1);
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign dl.delayed = st.out;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_up_due;
        dl.enable_level && st.en_d && !st.out && st.step == dl.start_code;
    endsequence
    sequence s_down_due;
        !dl.enable_level && !st.en_d && st.out && st.step == dl.stop_code;
    endsequence
    a_start_due:
        assert property (s_up_due |=> st.out) else $error("startup delay missed");
    a_stop_due:
        assert property (s_down_due |=> !st.out) else $error("shutdown delay missed");
    a_rise_on_code:
        assert property ($rose(st.out) |-> $past(st.step) == $past(dl.start_code))
        else $error("output rose before its delay code");
endmodule
`default_nettype wire

/* File: src/gpc_config_top.sv */
// configuration registers, serial slave and pin logic of the power block
`timescale 1ns/1ps
`default_nettype none
module gpc_config_top #(
    parameter int unsigned STEP_FINE_CYCLES = gpc_pkg::STEP_FINE_US * gpc_pkg::CLK_MHZ,
    parameter int unsigned STEP_COARSE_CYCLES = gpc_pkg::STEP_COARSE_US * gpc_pkg::CLK_MHZ,
    // bus address, value arbitrary
    parameter logic [6:0] DEVICE_ADDR = gpc_pkg::DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial control interface
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // enable pin and rail comparators
    input wire logic enable_pin,
    input wire logic [3:0] rail_uv_ok,
    input wire logic [3:0] rail_ov_ok,
    // general output a pin
    output logic general_output_a_out,
    output logic general_output_a_oe,
    // clock pin, also general output b
    input wire logic external_clock_pin_in,
    output logic external_clock_pin_out,
    output logic external_clock_pin_oe,
    // power good pin
    output logic power_ok_output_out,
    output logic power_ok_output_oe,
    // analog and clocking controls
    output logic clock_pin_function,
    output logic clock_pin_pulldown,
    output logic enable_pin_pulldown,
    output logic thermal_warning_level,
    output logic spread_spectrum_on,
    output logic loop_enable,
    output logic use_external_clock,
    output logic [4:0] external_clock_rate,
    output logic external_clock_event
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_REG = 3'b010,
        S_WDATA = 3'b011,
        S_ACK = 3'b100,
        S_RDATA = 3'b101,
        S_RACK = 3'b110
    } gpc_bus_state_type;

    typedef struct packed {
        gpc_bus_state_type bus;
        gpc_bus_state_type after_ack;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic scl_d;
        logic sda_d;
        logic sda_oe;
        logic [7:0] dly_a;
        logic [7:0] dly_b;
        logic [7:0] out_ctrl;
        logic [7:0] misc;
        logic [7:0] loop;
        logic [7:0] power_ok_output;
        logic clk_d;
        logic [9:0] idle_cnt;
        logic present;
        logic evt;
        logic a_out;
        logic a_oe;
        logic b_out;
        logic b_oe;
        logic p_out;
        logic p_oe;
    } gpc_top_state_type;

    gpc_top_state_type st, next_st;
    logic [11:0] filt;
    logic f_scl, f_sda, f_en, f_clk;
    logic [3:0] f_uv, f_ov;
    logic rise, fall, start, stop;
    logic [7:0] rd;
    logic [7:0] status;
    logic lvl_a, lvl_b, loop_on, clk_edge, good;
    logic [3:0] valid, window;

    gpc_delay_if dl_a ();
    gpc_delay_if dl_b ();

    // slow pins and comparators cross into clk here; bus lines idle high
    gpc_sync #(.W(12), .INIT(12'h003)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .raw({rail_ov_ok, rail_uv_ok, external_clock_pin_in, enable_pin, sda_in, scl_in}),
        .filtered(filt)
    );
    assign f_scl = filt[0];
    assign f_sda = filt[1];
    assign f_en = filt[2];
    assign f_clk = filt[3];
    assign f_uv = filt[7:4];
    assign f_ov = filt[11:8];

    assign dl_a.enable_level = f_en;
    assign dl_a.start_code = st.dly_a[3:0];
    assign dl_a.stop_code = st.dly_a[7:4];
    assign dl_a.start_coarse = st.misc[gpc_pkg::M_START_SEL];
    assign dl_a.stop_coarse = st.misc[gpc_pkg::M_STOP_SEL];
    assign dl_b.enable_level = f_en;
    assign dl_b.start_code = st.dly_b[3:0];
    assign dl_b.stop_code = st.dly_b[7:4];
    assign dl_b.start_coarse = st.misc[gpc_pkg::M_START_SEL];
    assign dl_b.stop_coarse = st.misc[gpc_pkg::M_STOP_SEL];

    gpc_delay #(.FINE_CYCLES(STEP_FINE_CYCLES), .COARSE_CYCLES(STEP_COARSE_CYCLES)) u_dly_a (
        .clk(clk),
        .rst_n(rst_n),
        .dl(dl_a)
    );
    gpc_delay #(.FINE_CYCLES(STEP_FINE_CYCLES), .COARSE_CYCLES(STEP_COARSE_CYCLES)) u_dly_b (
        .clk(clk),
        .rst_n(rst_n),
        .dl(dl_b)
    );

    assign rise = f_scl && !st.scl_d;
    assign fall = !f_scl && st.scl_d;
    assign start = f_scl && st.scl_d && st.sda_d && !f_sda;
    assign stop = f_scl && st.scl_d && !st.sda_d && f_sda;

    // level bit alone, or level and delayed enable
    assign lvl_a = st.out_ctrl[gpc_pkg::B_LEVEL_A]
        && (!st.out_ctrl[gpc_pkg::B_GATE_A] || dl_a.delayed);
    assign lvl_b = st.out_ctrl[gpc_pkg::B_LEVEL_B]
        && (!st.out_ctrl[gpc_pkg::B_GATE_B] || dl_b.delayed);

    // rail order: switcher 0, switcher 1, linear 0, linear 1
    assign window = {{2{st.power_ok_output[gpc_pkg::P_WIN_LIN]}}, {2{st.power_ok_output[gpc_pkg::P_WIN_SW]}}};
    assign valid = f_uv & (~window | f_ov);
    assign good = &(valid | ~st.power_ok_output[3:0]);

    assign loop_on = st.loop[gpc_pkg::L_LOOP_EN] && st.misc[gpc_pkg::M_PIN_FN];
    assign clk_edge = f_clk != st.clk_d;
    assign status = {2'h0, f_en, dl_b.delayed, dl_a.delayed, use_external_clock, st.present,
        good};

    always_comb begin
        case (st.ptr)
            gpc_pkg::ADDR_OUT_A_DELAY: rd = st.dly_a;
            gpc_pkg::ADDR_OUT_B_DELAY: rd = st.dly_b;
            gpc_pkg::ADDR_OUT_CTRL: rd = st.out_ctrl;
            gpc_pkg::ADDR_MISC: rd = st.misc;
            gpc_pkg::ADDR_LOOP: rd = st.loop;
            gpc_pkg::ADDR_POWER_OK_OUTPUT: rd = st.power_ok_output;
            gpc_pkg::ADDR_STATUS: rd = status;
            default: rd = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.scl_d = f_scl;
        next_st.sda_d = f_sda;
        if (start) begin
            next_st.bus = S_ADDR;
            next_st.cnt = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (stop) begin
            next_st.bus = S_IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            case (st.bus)
                S_ADDR, S_REG, S_WDATA: begin
                    if (rise && st.cnt != 4'h8) begin
                        next_st.shreg = {st.shreg[6:0], f_sda};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (fall && st.cnt == 4'h8) begin
                        next_st.cnt = 4'h0;
                        next_st.bus = S_ACK;
                        next_st.sda_oe = 1'b1;
                        if (st.bus == S_ADDR) begin
                            next_st.after_ack = st.shreg[0] ? S_RDATA : S_REG;
                            // another slave's address: stay off the bus
                            if (st.shreg[7:1] != DEVICE_ADDR) begin
                                next_st.bus = S_IDLE;
                                next_st.sda_oe = 1'b0;
                            end
                        end else if (st.bus == S_REG) begin
                            next_st.ptr = st.shreg;
                            next_st.after_ack = S_WDATA;
                        end else begin
                            next_st.after_ack = S_WDATA;
                            next_st.ptr = st.ptr + 8'h01;
                            case (st.ptr)
                                gpc_pkg::ADDR_OUT_A_DELAY: next_st.dly_a = st.shreg;
                                gpc_pkg::ADDR_OUT_B_DELAY: next_st.dly_b = st.shreg;
                                // reserved bits 7 and 3 stay zero
                                gpc_pkg::ADDR_OUT_CTRL:
                                    next_st.out_ctrl = st.shreg & gpc_pkg::OUT_CTRL_WMASK;
                                gpc_pkg::ADDR_MISC: next_st.misc = st.shreg;
                                // bit 5 and rate codes above 8'h17 kept as written
                                gpc_pkg::ADDR_LOOP: next_st.loop = st.shreg;
                                gpc_pkg::ADDR_POWER_OK_OUTPUT: next_st.power_ok_output = st.shreg;
                                default: next_st.ptr = st.ptr + 8'h01;
                            endcase
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        next_st.bus = st.after_ack;
                        next_st.cnt = 4'h0;
                        next_st.sda_oe = 1'b0;
                        if (st.after_ack == S_RDATA) begin
                            next_st.shreg = rd;
                            next_st.sda_oe = !rd[7];
                        end
                    end
                end
                S_RDATA: begin
                    if (fall) begin
                        next_st.cnt = st.cnt + 4'h1;
                        if (st.cnt == 4'h7) begin
                            next_st.sda_oe = 1'b0;
                            next_st.bus = S_RACK;
                            next_st.ptr = st.ptr + 8'h01;
                        end else begin
                            next_st.shreg = {st.shreg[6:0], 1'b0};
                            next_st.sda_oe = !st.shreg[6];
                        end
                    end
                end
                S_RACK: begin
                    // a master nack ends the read
                    if (rise && f_sda) begin
                        next_st.bus = S_IDLE;
                    end else if (fall) begin
                        next_st.bus = S_RDATA;
                        next_st.cnt = 4'h0;
                        next_st.shreg = rd;
                        next_st.sda_oe = !rd[7];
                    end
                end
                default: begin
                    next_st.bus = S_IDLE;
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end

        // presence needs an edge at least every two slowest clock periods
        next_st.clk_d = f_clk;
        if (!loop_on) begin
            next_st.present = 1'b0;
            next_st.idle_cnt = '0;
        end else if (clk_edge) begin
            next_st.present = 1'b1;
            next_st.idle_cnt = '0;
        end else if (st.idle_cnt == 10'(gpc_pkg::PRESENCE_CYCLES - 1)) begin
            next_st.present = 1'b0;
        end else begin
            next_st.idle_cnt = st.idle_cnt + 10'h001;
        end
        next_st.evt = st.loop[gpc_pkg::L_LOOP_EN] && (next_st.present != st.present);

        next_st.a_out = !st.out_ctrl[gpc_pkg::B_OD_A] && lvl_a;
        next_st.a_oe = st.out_ctrl[gpc_pkg::B_OD_A] ? !lvl_a : 1'b1;
        if (st.misc[gpc_pkg::M_PIN_FN]) begin
            next_st.b_out = 1'b0;
            next_st.b_oe = 1'b0;
        end else begin
            next_st.b_out = !st.out_ctrl[gpc_pkg::B_OD_B] && lvl_b;
            next_st.b_oe = st.out_ctrl[gpc_pkg::B_OD_B] ? !lvl_b : 1'b1;
        end
        next_st.p_out = !st.power_ok_output[gpc_pkg::P_OD] && (good ^ st.power_ok_output[gpc_pkg::P_POL]);
        next_st.p_oe = st.power_ok_output[gpc_pkg::P_OD]
            ? !(good ^ st.power_ok_output[gpc_pkg::P_POL]) : 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.scl_d <= 1'b1;
            st.sda_d <= 1'b1;
            st.dly_a <= gpc_pkg::RST_DELAY;
            st.dly_b <= gpc_pkg::RST_DELAY;
            st.out_ctrl <= gpc_pkg::RST_OUT_CTRL;
            st.misc <= gpc_pkg::RST_MISC;
            st.loop <= gpc_pkg::RST_LOOP;
            st.power_ok_output <= gpc_pkg::RST_POWER_OK_OUTPUT;
        end else begin
            st <= next_st;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = st.sda_oe;
    assign general_output_a_out = st.a_out;
    assign general_output_a_oe = st.a_oe;
    assign external_clock_pin_out = st.b_out;
    assign external_clock_pin_oe = st.b_oe;
    assign power_ok_output_out = st.p_out;
    assign power_ok_output_oe = st.p_oe;
    assign clock_pin_function = st.misc[gpc_pkg::M_PIN_FN];
    assign clock_pin_pulldown = st.misc[gpc_pkg::M_CLK_PD];
    assign enable_pin_pulldown = st.misc[gpc_pkg::M_ENABLE_PIN_PULLDOWN];
    assign thermal_warning_level = st.misc[gpc_pkg::M_THERM];
    assign spread_spectrum_on = st.misc[gpc_pkg::M_SPREAD];
    assign loop_enable = st.loop[gpc_pkg::L_LOOP_EN];
    assign use_external_clock = st.present;
    assign external_clock_rate = st.loop[4:0];
    assign external_clock_event = st.evt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_a_push_pull:
        assert property (!st.out_ctrl[gpc_pkg::B_OD_A]
            |=> general_output_a_oe && general_output_a_out == $past(lvl_a))
        else $error("output a push-pull drive wrong");
    a_a_gated:
        assert property (st.out_ctrl[gpc_pkg::B_GATE_A] && !dl_a.delayed
            |=> !general_output_a_out)
        else $error("output a high while enable gate closed");
    a_a_level:
        assert property (!st.out_ctrl[gpc_pkg::B_GATE_A] && !st.out_ctrl[gpc_pkg::B_OD_A]
            |=> general_output_a_out == $past(st.out_ctrl[gpc_pkg::B_LEVEL_A]))
        else $error("output a level not followed");
    a_b_open_drain:
        assert property (!st.misc[gpc_pkg::M_PIN_FN] && st.out_ctrl[gpc_pkg::B_OD_B]
            |=> !external_clock_pin_out && external_clock_pin_oe == !$past(lvl_b))
        else $error("output b open-drain drive wrong");
    a_b_gated:
        assert property (st.out_ctrl[gpc_pkg::B_GATE_B] && !dl_b.delayed
            |=> !external_clock_pin_out)
        else $error("output b high while enable gate closed");
    a_b_level:
        assert property (!st.misc[gpc_pkg::M_PIN_FN] && !st.out_ctrl[gpc_pkg::B_GATE_B]
            && !st.out_ctrl[gpc_pkg::B_OD_B]
            |=> external_clock_pin_out == $past(st.out_ctrl[gpc_pkg::B_LEVEL_B]))
        else $error("output b level not followed");
    a_pin_input:
        assert property (st.misc[gpc_pkg::M_PIN_FN] |=> !external_clock_pin_oe)
        else $error("clock pin driven while used as input");
    a_pok_level:
        assert property (!st.power_ok_output[gpc_pkg::P_OD] |=> power_ok_output_oe
            && power_ok_output_out == ($past(good) ^ $past(st.power_ok_output[gpc_pkg::P_POL])))
        else $error("power good level or polarity wrong");
    a_pok_drain:
        assert property (st.power_ok_output[gpc_pkg::P_OD] |=> !power_ok_output_out
            && power_ok_output_oe == !($past(good) ^ $past(st.power_ok_output[gpc_pkg::P_POL])))
        else $error("power good open-drain drive wrong");
    a_loop_off:
        assert property (!st.loop[gpc_pkg::L_LOOP_EN] |=> !use_external_clock)
        else $error("external clock used with loop off");
    a_clock_event:
        assert property ($changed(st.present) && $past(st.loop[gpc_pkg::L_LOOP_EN])
            |-> external_clock_event)
        else $error("external clock change without event");
endmodule
`default_nettype wire

/* File: testbench/gpc_host_model.sv */
// serial host model for the control interface
`timescale 1ns/1ps
`default_nettype none
module gpc_host_model (
    // clock, line level
    input wire logic clk,
    input wire logic sda,
    // driven lines
    output var logic scl = 1'b1,
    output var logic sda_low = 1'b0
);
    // data moves 2 clk after scl so no edge reads as start or stop
    task automatic step(input logic c, input logic d);
        scl <= c;
        repeat (2) @(posedge clk);
        sda_low <= d;
        repeat (8) @(posedge clk);
    endtask
    // start (also repeated) or stop
    task automatic cond(input logic s);
        step(1'b0, !s);
        step(1'b1, !s);
        step(1'b1, s);
    endtask
    // byte plus ack bit; 8'hff reads a byte and nacks it
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nak);
        logic [8:0] x;
        logic [8:0] r;
        x = {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, !x[i]);
            step(1'b1, !x[i]);
            r = {r[7:0], sda};
        end
        q = r[8:1];
        nak = r[0];
    endtask
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        logic n0;
        logic n1;
        logic n2;
        cond(1'b1);
        byte_io({gpc_pkg::DEV_ADDR_DEFAULT, 1'b0}, q, n0);
        byte_io(a, q, n1);
        if (rd)
            cond(1'b1);
        if (rd)
            byte_io({gpc_pkg::DEV_ADDR_DEFAULT, 1'b1}, q, n2);
        byte_io(d, q, n2);
        cond(1'b0);
        ok = !(n0 | n1 | (n2 & !rd));
    endtask
endmodule
`default_nettype wire

/* File: testbench/gpc_config_top_tb_top.sv */
// bench for the configuration block
`timescale 1ns/1ps
`default_nettype none
module gpc_config_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic ckin = 1'b0;
    logic [3:0] uv = 4'hf;
    logic [3:0] ov = 4'hf;
    logic scl, sda_low, sda_oe, a_out, a_oe, b_out, b_oe, pg_out, pg_oe;
    logic cpf, cpd, epd, thw, ssp, lpe, uxc, xev, sdo;
    logic [4:0] rate;
    int errors = 0;
    int n_compared = 0;
    int ev = 0;
    // pull-up on the data line
    // open drain: the device pulls low only while it drives a zero
    wire logic sda = !(sda_low | (sda_oe & !sdo));
    always #2 clk = !clk;
    always @(posedge clk) if (xev === 1'b1) ev <= ev + 1;
    gpc_config_top #(.STEP_FINE_CYCLES(4), .STEP_COARSE_CYCLES(8)) gpc_config_top_i (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe),
        .enable_pin(en), .rail_uv_ok(uv), .rail_ov_ok(ov),
        .general_output_a_out(a_out), .general_output_a_oe(a_oe),
        .external_clock_pin_in(ckin), .external_clock_pin_out(b_out),
        .external_clock_pin_oe(b_oe), .power_ok_output_out(pg_out), .power_ok_output_oe(pg_oe),
        .clock_pin_function(cpf), .clock_pin_pulldown(cpd), .enable_pin_pulldown(epd),
        .thermal_warning_level(thw), .spread_spectrum_on(ssp), .loop_enable(lpe),
        .use_external_clock(uxc), .external_clock_rate(rate), .external_clock_event(xev));
    gpc_host_model gpc_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        gpc_host_model_i.xfer(1'b0, a, d, q, ok);
        chk("ack", 8'h01, {7'h0, ok});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic ok;
        gpc_host_model_i.xfer(1'b1, a, 8'hff, q, ok);
        chk("ack", 8'h01, {7'h0, ok});
        chk("reg", e, q);
    endtask
    // oe, out of a pin: open drain pulls low only for level 0
    function automatic logic [7:0] pin(input logic [2:0] c, input logic e);
        logic v;
        v = c[0] & (!c[1] | e);
        return c[2] ? {6'h0, !v, 1'b0} : {6'h0, 1'b1, v};
    endfunction
    task automatic toggle;
        repeat (40) begin
            ckin <= !ckin;
            cyc(4);
        end
    endtask
    task automatic t_reset;
        rd(8'h12, 8'h44);
        rd(8'h13, 8'h1f);
        rd(8'h14, 8'h01);
        rd(8'h15, 8'h70);
        rd(8'h30, 8'h00);
        chk("sda_out", 8'h00, {7'h0, sdo});
        chk("misc", 8'h1f, {3'h0, cpf, cpd, epd, thw, ssp});
    endtask
    task automatic t_pins;
        logic [7:0] c;
        wr(8'h13, 8'h08);
        chk("misc", 8'h08, {3'h0, cpf, cpd, epd, thw, ssp});
        for (int e = 0; e < 2; e++) begin
            en <= e[0];
            for (int k = 0; k < 8; k++) begin
                c = {1'b0, k[2:0], 1'b0, k[2:0]};
                wr(8'h12, c);
                cyc(20);
                chk("pin_a", pin(c[2:0], e[0]), {6'h0, a_oe, a_out});
                chk("pin_b", pin(c[6:4], e[0]), {6'h0, b_oe, b_out});
            end
        end
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h77);
        wr(8'h13, 8'h18);
        en <= 1'b0;
        chk("pin_b", 8'h00, {7'h0, b_oe});
    endtask
    // bounded wait for output a; running out counts as a mismatch
    task automatic wait_a(input logic lv, output int n);
        n = 0;
        while (a_out !== lv && n < 200) begin
            cyc(1);
            n++;
        end
        if (a_out !== lv) begin
            errors++;
            report_and_stop;
        end
    endtask
    task automatic t_delay;
        int n;
        int st;
        wr(8'h10, 8'h23);
        wr(8'h12, 8'h03);
        for (int s = 0; s < 2; s++) begin
            st = s ? 8 : 4;
            wr(8'h13, s ? 8'h78 : 8'h18);
            en <= 1'b1;
            wait_a(1'b1, n);
            chk("delay", 8'h01, {7'h0, n >= 3 * st && n <= 3 * st + 10});
            en <= 1'b0;
            wait_a(1'b0, n);
            chk("delay", 8'h01, {7'h0, n >= 2 * st && n <= 2 * st + 10});
        end
    endtask
    task automatic t_clock;
        wr(8'h14, 8'h57);
        chk("loop", 8'h37, {2'h0, lpe, rate});
        toggle;
        chk("ext", 8'h01, {7'h0, uxc});
        cyc(700);
        chk("ext", 8'h00, {7'h0, uxc});
        wr(8'h14, 8'h17);
        toggle;
        chk("ext", 8'h00, {7'h0, uxc});
        chk("events", 8'h02, ev[7:0]);
        rd(8'h20, 8'h01);
    endtask
    task automatic t_power_ok_output;
        logic [15:0] v[6] = '{16'h6fff, 16'h6ffb, 16'h0ffb, 16'h8ffb, 16'h4eef, 16'h5ffe};
        logic [7:0] c;
        logic g;
        foreach (v[i]) begin
            c = v[i][15:8];
            uv <= v[i][7:4];
            ov <= v[i][3:0];
            wr(8'h15, c);
            g = &(~c[3:0] | (v[i][7:4] & (v[i][3:0] | ~{c[5], c[5], c[4], c[4]})));
            chk("power_ok_output", pin({c[6], 1'b0, g ^ c[7]}, 1'b0), {6'h0, pg_oe, pg_out});
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(10);
        t_reset;
        t_pins;
        t_delay;
        t_clock;
        t_power_ok_output;
        report_and_stop;
    end
endmodule
`default_nettype wire
